// >>> design/system_clock_reset_power_control.sv
// system clock, reset sequencing and power mode control with apb registers
//
// What this block does
// - pll multiplier accepts every integer setting from 1 to 32.
// - post divider offers only divide by 2, 4, 8 or 16.
// - after chip reset the pll is off and bypassed.
// - the pll reports lock within its 100 us settling time.
// - core clock is the oscillator unless pll runs and is connected.
// - chip reset comes from the reset pin or the watchdog.
// - internal reset holds until pin, oscillator, count and flash are done.
// - on release registers hold reset values and fetch starts at zero.
// - every power-down exit runs the wake-up timer before execution.
// - nine external pins merge into four requests, each may wake.
// - a map control picks flash or ram for the vectors at zero.
// - idle stops the processor until reset or interrupt, peripherals run.
// - power-down stops the oscillator and all clocks, state retained.
// - power-down ends only on reset or a clockless interrupt.
// - each peripheral can be powered off on its own.
// - peripheral clock runs at full, half or quarter core rate.
// - after reset the peripheral divider is at one quarter.
// - a running pll stays active during idle.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module system_clock_reset_power_control #(
	parameter int NUM_PERIPH  = sys_ctrl_pkg::NUM_PERIPH,
	parameter int NUM_EXT_PIN = sys_ctrl_pkg::NUM_EXT_PIN,
	parameter int NUM_EXT_CH  = sys_ctrl_pkg::NUM_EXT_CH,
	parameter int LOCK_CYCLES = sys_ctrl_pkg::PLL_LOCK_CYCLES,
	parameter int WAKE_CYCLES = sys_ctrl_pkg::WAKE_CYCLES
) (
	// clock and control
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic                     clkEn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// pins
	input  wire logic                     rstPinN,
	input  wire logic                     oscStable,
	input  wire logic [NUM_EXT_PIN-1:0]   extIntPin,
	// on-chip sources
	input  wire logic                     wdtReset,
	input  wire logic                     flashInitDone,
	input  wire logic                     irqPending,
	// clock and pll controls
	output logic                          oscEnable,
	output logic                          pllPowerOn,
	output logic [5:0]                    pllMult,
	output logic [4:0]                    pllDiv,
	output logic                          pllConnected,
	output logic                          coreClkEn,
	output logic                          periphClkEn,
	// reset and power
	output logic                          sysRst,
	output logic                          flashInitStart,
	output logic [NUM_PERIPH-1:0]         periphPowerEn,
	output logic                          vectorMapRam,
	output logic [NUM_EXT_CH-1:0]         extIntReq
);

	localparam int LW = $clog2(LOCK_CYCLES + 1);
	localparam int WW = $clog2(WAKE_CYCLES);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic                   rstPinLvlN;
	logic                   oscOk;
	logic [NUM_EXT_PIN-1:0] pinLvl;

	pin_sync #(
		.WIDTH (NUM_EXT_PIN + 2),
		.INIT  ({{NUM_EXT_PIN{1'b0}}, 2'b01})
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.din      ({extIntPin, oscStable, rstPinN}),
		.dout     ({pinLvl, oscOk, rstPinLvlN})
	);

	// ----------------------------------------------------------------
	// state declarations
	// ----------------------------------------------------------------
	sys_ctrl_pkg::wake_state_t state;
	sys_ctrl_pkg::wake_state_t next_state;
	logic [WW-1:0]         wakeCnt;
	logic [WW-1:0]         next_wakeCnt;
	logic                  fromPdown;
	logic                  next_fromPdown;
	logic                  pllEnable;
	logic                  next_pllEnable;
	logic                  pllConnect;
	logic                  next_pllConnect;
	logic [4:0]            msel;
	logic [4:0]            next_msel;
	logic [1:0]            psel2;
	logic [1:0]            next_psel2;
	logic                  idleReq;
	logic                  next_idleReq;
	logic                  pdownReq;
	logic                  next_pdownReq;
	logic [NUM_PERIPH-1:0] periphPower;
	logic [NUM_PERIPH-1:0] next_periphPower;
	logic [1:0]            pbusDiv;
	logic [1:0]            next_pbusDiv;
	logic                  mapRam;
	logic                  next_mapRam;
	logic [NUM_EXT_CH-1:0] wakeEn;
	logic [NUM_EXT_CH-1:0] next_wakeEn;
	logic [NUM_EXT_CH-1:0] extMode;
	logic [NUM_EXT_CH-1:0] next_extMode;
	logic [NUM_EXT_CH-1:0] extPolar;
	logic [NUM_EXT_CH-1:0] next_extPolar;
	logic [NUM_EXT_PIN-1:0] pinSel;
	logic [NUM_EXT_PIN-1:0] next_pinSel;
	logic [NUM_EXT_CH-1:0] extFlag;
	logic [NUM_EXT_CH-1:0] next_extFlag;
	logic [NUM_EXT_CH-1:0] lvlPrev;
	logic [1:0]            rstSrc;
	logic [1:0]            next_rstSrc;
	logic [LW-1:0]         lockCnt;
	logic [LW-1:0]         next_lockCnt;
	logic [1:0]            pclkCnt;
	logic                  ack;
	logic                  next_ack;
	logic [31:0]           next_prdata;
	logic                  mapped;
	logic                  wr;
	logic                  pllLocked;
	logic                  resetReq;
	logic                  pclkTick;
	logic [NUM_EXT_PIN-1:0] pinAct;
	logic [NUM_EXT_CH-1:0] chanLvl;

	// ----------------------------------------------------------------
	// wake-up timer and power modes
	// ----------------------------------------------------------------
	// two reset sources
	assign resetReq = wdtReset | ~rstPinLvlN;

	always_comb
	begin
		next_state     = state;
		next_wakeCnt   = wakeCnt;
		next_fromPdown = fromPdown;
		if (resetReq)
		begin
			next_state     = sys_ctrl_pkg::WU_RESET;
			next_wakeCnt   = '0;
			next_fromPdown = 1'b0;
		end
		else
		begin
			unique case (state)
				sys_ctrl_pkg::WU_RESET:
					next_state = sys_ctrl_pkg::WU_OSC;
				sys_ctrl_pkg::WU_OSC:
					if (oscOk)
					begin
						next_state   = sys_ctrl_pkg::WU_COUNT;
						next_wakeCnt = '0;
					end
				sys_ctrl_pkg::WU_COUNT:
					if (wakeCnt == WW'(WAKE_CYCLES - 1))
					begin
						next_state     = fromPdown ? sys_ctrl_pkg::WU_RUN
						                           : sys_ctrl_pkg::WU_FLASH;
						next_fromPdown = 1'b0;
					end
					else
						next_wakeCnt = wakeCnt + 1'b1;
				sys_ctrl_pkg::WU_FLASH:
					if (flashInitDone)
						next_state = sys_ctrl_pkg::WU_RUN;
				sys_ctrl_pkg::WU_RUN:
					if (pdownReq)
						next_state = sys_ctrl_pkg::WU_PDOWN;
					else if (idleReq)
						next_state = sys_ctrl_pkg::WU_IDLE;
				sys_ctrl_pkg::WU_IDLE:
					if (irqPending || (|extFlag))
						next_state = sys_ctrl_pkg::WU_RUN;
				sys_ctrl_pkg::WU_PDOWN:
					if (|(chanLvl & wakeEn))
					begin
						next_state     = sys_ctrl_pkg::WU_OSC;
						next_fromPdown = 1'b1;
					end
				default:
					next_state = sys_ctrl_pkg::WU_RESET;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state     <= sys_ctrl_pkg::WU_RESET;
			wakeCnt   <= '0;
			fromPdown <= 1'b0;
		end
		else if (clkEn)
		begin
			state     <= next_state;
			wakeCnt   <= next_wakeCnt;
			fromPdown <= next_fromPdown;
		end
	end

	// internal reset held through the sequence
	assign sysRst = (state == sys_ctrl_pkg::WU_RESET) || (state == sys_ctrl_pkg::WU_FLASH)
	             || (!fromPdown && ((state == sys_ctrl_pkg::WU_OSC)
	                             || (state == sys_ctrl_pkg::WU_COUNT)));
	assign flashInitStart = (state == sys_ctrl_pkg::WU_FLASH);
	assign coreClkEn = (state == sys_ctrl_pkg::WU_RUN);
	assign oscEnable = (state != sys_ctrl_pkg::WU_PDOWN);

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	assign wr = pready & pwrite;

	always_comb
	begin
		next_pllEnable   = pllEnable;
		next_pllConnect  = pllConnect;
		next_msel        = msel;
		next_psel2       = psel2;
		next_idleReq     = idleReq;
		next_pdownReq    = pdownReq;
		next_periphPower = periphPower;
		next_pbusDiv     = pbusDiv;
		next_mapRam      = mapRam;
		next_wakeEn      = wakeEn;
		next_extMode     = extMode;
		next_extPolar    = extPolar;
		next_pinSel      = pinSel;
		if (wr)
		begin
			case (paddr)
				sys_ctrl_pkg::OFS_PLL_CTRL:
				begin
					next_pllEnable  = pwdata[sys_ctrl_pkg::CTRL_ENABLE_BIT];
					next_pllConnect = pwdata[sys_ctrl_pkg::CTRL_CONNECT_BIT];
				end
				sys_ctrl_pkg::OFS_PLL_CFG:
				begin
					next_msel  = pwdata[sys_ctrl_pkg::CFG_MSEL_LSB +: 5];
					next_psel2 = pwdata[sys_ctrl_pkg::CFG_PSEL_LSB +: 2];
				end
				sys_ctrl_pkg::OFS_POWER_CTRL:
				begin
					next_idleReq  = pwdata[sys_ctrl_pkg::POWER_IDLE_BIT];
					next_pdownReq = pwdata[sys_ctrl_pkg::POWER_PDOWN_BIT];
				end
				sys_ctrl_pkg::OFS_PERIPH_POWER: next_periphPower = pwdata[NUM_PERIPH-1:0];
				sys_ctrl_pkg::OFS_PBUS_DIV:     next_pbusDiv     = pwdata[1:0];
				sys_ctrl_pkg::OFS_MEM_MAP:      next_mapRam      = pwdata[0];
				sys_ctrl_pkg::OFS_EXT_WAKE:     next_wakeEn      = pwdata[NUM_EXT_CH-1:0];
				sys_ctrl_pkg::OFS_EXT_MODE:     next_extMode     = pwdata[NUM_EXT_CH-1:0];
				sys_ctrl_pkg::OFS_EXT_POLAR:    next_extPolar    = pwdata[NUM_EXT_CH-1:0];
				sys_ctrl_pkg::OFS_EXT_PIN_SEL:  next_pinSel      = pwdata[NUM_EXT_PIN-1:0];
				default: ;
			endcase
		end
		// mode bits drop once the chip is back in run
		if (state != sys_ctrl_pkg::WU_RUN && next_state == sys_ctrl_pkg::WU_RUN)
		begin
			next_idleReq  = 1'b0;
			next_pdownReq = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		// pll off and bypassed after any reset
		if (rst || (clkEn && sysRst))
		begin
			pllEnable   <= 1'b0;
			pllConnect  <= 1'b0;
			msel        <= sys_ctrl_pkg::MSEL_RST;
			psel2       <= sys_ctrl_pkg::PSEL_RST;
			idleReq     <= 1'b0;
			pdownReq    <= 1'b0;
			periphPower <= '1;
			pbusDiv     <= sys_ctrl_pkg::PBUS_DIV_RST;
			mapRam      <= sys_ctrl_pkg::MAP_RST;
			wakeEn      <= '0;
			extMode     <= '0;
			extPolar    <= '1;
			pinSel      <= '0;
		end
		else if (clkEn)
		begin
			pllEnable   <= next_pllEnable;
			pllConnect  <= next_pllConnect;
			msel        <= next_msel;
			psel2       <= next_psel2;
			idleReq     <= next_idleReq;
			pdownReq    <= next_pdownReq;
			periphPower <= next_periphPower;
			pbusDiv     <= next_pbusDiv;
			mapRam      <= next_mapRam;
			wakeEn      <= next_wakeEn;
			extMode     <= next_extMode;
			extPolar    <= next_extPolar;
			pinSel      <= next_pinSel;
		end
	end

	assign periphPowerEn = periphPower;
	assign vectorMapRam  = mapRam;
	assign pllMult       = {1'b0, msel} + 6'h01;
	// only 2, 4, 8, 16 can be formed
	assign pllDiv        = 5'h02 << psel2;

	// ----------------------------------------------------------------
	// pll lock and peripheral divider
	// ----------------------------------------------------------------
	// idle leaves the pll powered
	assign pllPowerOn = pllEnable && !sysRst && (state != sys_ctrl_pkg::WU_PDOWN);
	// lock declared at the settling count
	assign pllLocked  = (lockCnt == LW'(LOCK_CYCLES));
	// bypass unless running, locked and connected
	assign pllConnected = pllPowerOn & pllConnect & pllLocked;

	always_comb
	begin
		next_lockCnt = lockCnt;
		// a new setting restarts the settling wait
		if (!pllPowerOn || (wr && paddr == sys_ctrl_pkg::OFS_PLL_CFG))
			next_lockCnt = '0;
		else if (!pllLocked)
			next_lockCnt = lockCnt + 1'b1;
		// full, half or quarter rate ticks
		unique case (pbusDiv)
			sys_ctrl_pkg::PBUS_FULL: pclkTick = 1'b1;
			sys_ctrl_pkg::PBUS_HALF: pclkTick = pclkCnt[0];
			default:                 pclkTick = (pclkCnt == 2'h3);
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			lockCnt <= '0;
			pclkCnt <= 2'h0;
		end
		else if (clkEn)
		begin
			lockCnt <= next_lockCnt;
			pclkCnt <= pclkCnt + 2'h1;
		end
	end

	// peripherals keep their clock in idle
	assign periphClkEn = pclkTick && ((state == sys_ctrl_pkg::WU_RUN)
	                               || (state == sys_ctrl_pkg::WU_IDLE));

	// ----------------------------------------------------------------
	// external interrupts and reset source flags
	// ----------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < NUM_EXT_PIN; gp++)
		begin : gen_pin
			// pin i feeds channel i mod channels
			assign pinAct[gp] = pinSel[gp] & ~(pinLvl[gp] ^ extPolar[gp % NUM_EXT_CH]);
		end
	endgenerate

	always_comb
	begin
		chanLvl = '0;
		for (int i = 0; i < NUM_EXT_PIN; i++)
			chanLvl[i % NUM_EXT_CH] = chanLvl[i % NUM_EXT_CH] | pinAct[i];
		// edge or level flag, set beats clear
		next_extFlag = extFlag;
		for (int c = 0; c < NUM_EXT_CH; c++)
		begin
			if (wr && paddr == sys_ctrl_pkg::OFS_EXT_FLAG && pwdata[c])
				next_extFlag[c] = 1'b0;
			if (extMode[c] ? (chanLvl[c] & ~lvlPrev[c]) : chanLvl[c])
				next_extFlag[c] = 1'b1;
		end
		next_rstSrc = rstSrc;
		if (wr && paddr == sys_ctrl_pkg::OFS_RESET_SRC)
			next_rstSrc = rstSrc & ~pwdata[1:0];
		if (!rstPinLvlN)
			next_rstSrc[sys_ctrl_pkg::RSRC_PIN_BIT] = 1'b1;
		if (wdtReset)
			next_rstSrc[sys_ctrl_pkg::RSRC_WDT_BIT] = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			extFlag <= '0;
			lvlPrev <= '0;
			rstSrc  <= 2'h0;
		end
		else if (clkEn)
		begin
			extFlag <= sysRst ? '0 : next_extFlag;
			lvlPrev <= chanLvl;
			rstSrc  <= next_rstSrc;
		end
	end

	assign extIntReq = extFlag;

	// ----------------------------------------------------------------
	// apb slave, one wait state, registered read data
	// ----------------------------------------------------------------
	always_comb
	begin
		next_ack    = psel & penable & ~ack;
		next_prdata = '0;
		mapped      = 1'b1;
		case (paddr)
			sys_ctrl_pkg::OFS_PLL_CTRL:
			begin
				next_prdata[sys_ctrl_pkg::CTRL_ENABLE_BIT]  = pllEnable;
				next_prdata[sys_ctrl_pkg::CTRL_CONNECT_BIT] = pllConnect;
			end
			sys_ctrl_pkg::OFS_PLL_CFG, sys_ctrl_pkg::OFS_PLL_STAT:
			begin
				next_prdata[sys_ctrl_pkg::CFG_MSEL_LSB +: 5] = msel;
				next_prdata[sys_ctrl_pkg::CFG_PSEL_LSB +: 2] = psel2;
				if (paddr == sys_ctrl_pkg::OFS_PLL_STAT)
				begin
					next_prdata[sys_ctrl_pkg::STAT_ENABLE_BIT]  = pllPowerOn;
					next_prdata[sys_ctrl_pkg::STAT_CONNECT_BIT] = pllConnected;
					next_prdata[sys_ctrl_pkg::STAT_LOCK_BIT]    = pllLocked;
				end
			end
			sys_ctrl_pkg::OFS_POWER_CTRL:   next_prdata[1:0] = {pdownReq, idleReq};
			sys_ctrl_pkg::OFS_PERIPH_POWER: next_prdata[NUM_PERIPH-1:0] = periphPower;
			sys_ctrl_pkg::OFS_PBUS_DIV:     next_prdata[1:0] = pbusDiv;
			sys_ctrl_pkg::OFS_MEM_MAP:      next_prdata[0] = mapRam;
			sys_ctrl_pkg::OFS_EXT_FLAG:     next_prdata[NUM_EXT_CH-1:0] = extFlag;
			sys_ctrl_pkg::OFS_EXT_WAKE:     next_prdata[NUM_EXT_CH-1:0] = wakeEn;
			sys_ctrl_pkg::OFS_EXT_MODE:     next_prdata[NUM_EXT_CH-1:0] = extMode;
			sys_ctrl_pkg::OFS_EXT_POLAR:    next_prdata[NUM_EXT_CH-1:0] = extPolar;
			sys_ctrl_pkg::OFS_EXT_PIN_SEL:  next_prdata[NUM_EXT_PIN-1:0] = pinSel;
			sys_ctrl_pkg::OFS_RESET_SRC:    next_prdata[1:0] = rstSrc;
			sys_ctrl_pkg::OFS_WAKE_STAT:    next_prdata[2:0] = state;
			default:                        mapped = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ack    <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (clkEn)
		begin
			ack <= next_ack;
			if (next_ack)
				prdata <= next_prdata;
		end
	end

	// pready gated by clkEn so a write never completes on a frozen edge
	assign pready  = psel & penable & ack & clkEn;
	assign pslverr = pready & ~mapped;

endmodule : system_clock_reset_power_control

// >>> design/sys_ctrl_pkg.sv
// constants, register map and state codes of the system clock, reset and power control
package sys_ctrl_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CORE_CLK_MHZ    = 125;
	localparam int PLL_SETTLE_US   = 100;
	// settling is a longest time, so the count rounds down
	localparam int PLL_LOCK_CYCLES = (PLL_SETTLE_US * CORE_CLK_MHZ * 1000) / 1000;
	localparam int WAKE_CYCLES     = 256;
	localparam int MULT_MIN        = 1;
	localparam int MULT_MAX        = 32;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W      = 8;
	localparam int NUM_PERIPH  = 16;
	localparam int NUM_EXT_PIN = 9;
	localparam int NUM_EXT_CH  = 4;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_PLL_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PLL_CFG      = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PLL_STAT     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_POWER_CTRL   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PERIPH_POWER = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PBUS_DIV     = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MEM_MAP      = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_EXT_FLAG     = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_EXT_WAKE     = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_EXT_MODE     = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_EXT_POLAR    = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_EXT_PIN_SEL  = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_RESET_SRC    = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_WAKE_STAT    = 8'h34;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int CTRL_CONNECT_BIT = 1;
	localparam int CFG_MSEL_LSB     = 0;
	localparam int CFG_PSEL_LSB     = 5;
	localparam int STAT_ENABLE_BIT  = 8;
	localparam int STAT_CONNECT_BIT = 9;
	localparam int STAT_LOCK_BIT    = 10;
	localparam int POWER_IDLE_BIT   = 0;
	localparam int POWER_PDOWN_BIT  = 1;
	localparam int RSRC_PIN_BIT     = 0;
	localparam int RSRC_WDT_BIT     = 1;

	// ----------------------------------------------------------------
	// field codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PBUS_QUARTER = 2'h0;
	localparam logic [1:0] PBUS_FULL    = 2'h1;
	localparam logic [1:0] PBUS_HALF    = 2'h2;
	localparam logic [1:0] PBUS_DIV_RST = PBUS_QUARTER;
	localparam logic [4:0] MSEL_RST     = 5'h00;
	localparam logic [1:0] PSEL_RST     = 2'h0;
	localparam logic       MAP_RST      = 1'b0;

	typedef enum logic [2:0] {
		WU_RESET = 3'b000,
		WU_OSC   = 3'b001,
		WU_COUNT = 3'b010,
		WU_FLASH = 3'b011,
		WU_RUN   = 3'b100,
		WU_IDLE  = 3'b101,
		WU_PDOWN = 3'b110
	} wake_state_t;

endpackage : sys_ctrl_pkg

// >>> design/pin_sync.sv
// three-stage synchroniser whose output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	// clock and control
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	// pins in, clean levels out
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : gen_bit
			logic s1;
			logic s2;
			logic s3;
			logic q;
			logic next_q;

			// a lone stray sample cannot move the output
			always_comb
			begin
				next_q = (s2 == s3) ? s3 : q;
			end

			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					s1 <= INIT[g];
					s2 <= INIT[g];
					s3 <= INIT[g];
					q  <= INIT[g];
				end
				else if (clkEn)
				begin
					s1 <= din[g];
					s2 <= s1;
					s3 <= s2;
					q  <= next_q;
				end
			end

			assign dout[g] = q;
		end
	endgenerate

endmodule : pin_sync

// >>> bench/sys_ctrl_asserts.sv
// checker for the system clock, reset and power control block
`timescale 1ns/1ps
module sys_ctrl_asserts (
	// clock and control
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       clkEn,
	input wire logic       wdtReset,
	// observed outputs
	input wire logic       oscEnable,
	input wire logic       pllPowerOn,
	input wire logic [5:0] pllMult,
	input wire logic [4:0] pllDiv,
	input wire logic       pllConnected,
	input wire logic       coreClkEn,
	input wire logic       periphClkEn,
	input wire logic       sysRst
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_mult; pllMult >= 6'h01 && pllMult <= 6'h20; endproperty
	a_mult: assert property (p_mult) else $error("multiplier out of range");
	property p_div; pllDiv inside {5'h02, 5'h04, 5'h08, 5'h10}; endproperty
	a_div: assert property (p_div) else $error("divider not 2 4 8 16");
	property p_rst; sysRst |=> !pllPowerOn && !pllConnected; endproperty
	a_rst: assert property (p_rst) else $error("pll active in reset");
	property p_conn; pllConnected |-> pllPowerOn; endproperty
	a_conn: assert property (p_conn) else $error("connected while off");
	property p_wdt; wdtReset && clkEn |=> sysRst; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog gave no reset");
	property p_hold; sysRst |-> !coreClkEn; endproperty
	a_hold: assert property (p_hold) else $error("core runs in reset");
	property p_wake; $rose(oscEnable) |-> !coreClkEn [*4]; endproperty
	a_wake: assert property (p_wake) else $error("wake timer skipped");
	property p_pdown; !oscEnable |-> !coreClkEn && !periphClkEn && !pllPowerOn; endproperty
	a_pdown: assert property (p_pdown) else $error("clock in power-down");
endmodule : sys_ctrl_asserts

bind system_clock_reset_power_control sys_ctrl_asserts u_chk (.core_clk, .rst, .clkEn,
	.wdtReset, .oscEnable, .pllPowerOn, .pllMult, .pllDiv, .pllConnected, .coreClkEn,
	.periphClkEn, .sysRst);

// >>> bench/system_clock_reset_power_control_test.sv
// self-checking bench for the system control block
`timescale 1ns/1ps
module system_clock_reset_power_control_test;
	logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic        oscEnable, pllPowerOn, pllConnected, coreClkEn, periphClkEn, sysRst;
	logic        vectorMapRam, err, wdtReset = 0, irqPending = 0, rstPinN = 1;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [8:0]  extIntPin = 9'h000;
	logic [5:0]  pllMult;
	logic [4:0]  pllDiv;
	logic [15:0] periphPowerEn;
	logic [3:0]  extIntReq;
	logic [4:0]  msel;
	int          failures = 0, n_compared = 0, seed = 32'hf174, n, pw;

	system_clock_reset_power_control #(.LOCK_CYCLES(20), .WAKE_CYCLES(4)) DUT (
		.core_clk, .rst, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rstPinN, .oscStable(1'b1), .extIntPin, .wdtReset,
		.flashInitDone(1'b1), .irqPending, .oscEnable, .pllPowerOn, .pllMult, .pllDiv,
		.pllConnected, .coreClkEn, .periphClkEn, .sysRst, .flashInitStart(),
		.periphPowerEn, .vectorMapRam, .extIntReq);

	initial forever #4 core_clk = ~core_clk;

	task automatic end_sim;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// holds the request until pready is seen at a rising edge, checks settle half a cycle on
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		@(negedge core_clk);
	endtask : apb

	task automatic run_wait;
		repeat (300)
		begin
			@(negedge core_clk);
			if (coreClkEn === 1'b1)
				break;
		end
		chk("coreClkEn", 1, coreClkEn);
	endtask : run_wait

	function automatic int per_count(input int c);
		return c == 1 ? 16 : c == 2 ? 8 : 4;
	endfunction : per_count

	task automatic pcount(input int e);
		n = 0;
		repeat (16)
		begin
			@(negedge core_clk);
			n += (periphClkEn === 1'b1);
		end
		chk("periph pulses", e, n);
	endtask : pcount

	initial
	begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		run_wait;
		chk("pllPowerOn", 0, pllPowerOn);
		pcount(4);
		for (int c = 1; c < 4; c++)
		begin
			apb(1, sys_ctrl_pkg::OFS_PBUS_DIV, c);
			pcount(per_count(c));
		end
		for (int k = 0; k < 6; k++)
		begin
			msel = k == 0 ? 5'h00 : k == 1 ? 5'h1F : 5'($random(seed));
			apb(1, sys_ctrl_pkg::OFS_PLL_CFG, {25'h0, 2'(k), msel});
			chk("pllMult", msel + 1, pllMult);
			chk("pllDiv", 2 << (k % 4), pllDiv);
		end
		apb(1, sys_ctrl_pkg::OFS_PLL_CFG, 32'h0000_0023);
		apb(1, sys_ctrl_pkg::OFS_PLL_CTRL, 1);
		apb(0, sys_ctrl_pkg::OFS_PLL_STAT, 0);
		chk("early lock", 0, rd[10]);
		repeat (20) @(posedge core_clk);
		apb(0, sys_ctrl_pkg::OFS_PLL_STAT, 0);
		chk("lock", 1, rd[10]);
		apb(1, sys_ctrl_pkg::OFS_PLL_CTRL, 3);
		chk("connected", 1, pllConnected);
		apb(1, sys_ctrl_pkg::OFS_PLL_CTRL, 1);
		chk("bypassed", 0, pllConnected);
		apb(1, sys_ctrl_pkg::OFS_POWER_CTRL, 1);
		@(negedge core_clk);
		chk("idle core", 0, coreClkEn);
		chk("idle pll", 1, pllPowerOn);
		pcount(4);
		@(posedge core_clk) irqPending <= 1'b1;
		run_wait;
		@(posedge core_clk) irqPending <= 1'b0;
		apb(1, sys_ctrl_pkg::OFS_PLL_CTRL, 0);
		pw = $random(seed);
		apb(1, sys_ctrl_pkg::OFS_PERIPH_POWER, pw);
		chk("periph power", 16'(pw), periphPowerEn);
		apb(1, sys_ctrl_pkg::OFS_MEM_MAP, 1);
		chk("map", 1, vectorMapRam);
		apb(1, sys_ctrl_pkg::OFS_EXT_PIN_SEL, 32'h20);
		apb(1, sys_ctrl_pkg::OFS_EXT_WAKE, 2);
		apb(1, sys_ctrl_pkg::OFS_POWER_CTRL, 2);
		repeat (10) @(negedge core_clk);
		chk("osc off", 0, oscEnable);
		@(posedge core_clk) extIntPin <= 9'h020;
		run_wait;
		chk("kept power", 16'(pw), periphPowerEn);
		chk("ext flag", 4'h2, extIntReq);
		@(posedge core_clk) extIntPin <= 9'h000;
		repeat (5) @(posedge core_clk);
		apb(1, sys_ctrl_pkg::OFS_EXT_FLAG, 2);
		chk("flag clear", 0, extIntReq);
		apb(0, 8'h3C, 0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		@(posedge core_clk) wdtReset <= 1'b1;
		@(posedge core_clk) wdtReset <= 1'b0;
		@(negedge core_clk);
		chk("sysRst", 1, sysRst);
		run_wait;
		chk("power reset", 32'hFFFF, periphPowerEn);
		apb(0, sys_ctrl_pkg::OFS_MEM_MAP, 0);
		chk("map reset", 0, rd[0]);
		apb(0, sys_ctrl_pkg::OFS_RESET_SRC, 0);
		chk("wdt source", 1, rd[1]);
		@(posedge core_clk) rstPinN <= 1'b0;
		repeat (8) @(negedge core_clk);
		chk("pin sysRst", 1, sysRst);
		@(posedge core_clk) rstPinN <= 1'b1;
		run_wait;
		apb(0, sys_ctrl_pkg::OFS_RESET_SRC, 0);
		chk("pin source", 1, rd[0]);
		pcount(4);
		end_sim;
	end

	initial
	begin
		repeat (6000) @(posedge core_clk);
		failures++;
		end_sim;
	end
endmodule : system_clock_reset_power_control_test
